// file: common/dtd_regs.vh
// constants for the drive telegram data-field block
`ifndef DTD_REGS_VH
`define DTD_REGS_VH
// ***********************
// framing
// ***********************
`define DTD_START_CHAR      8'h02
`define DTD_BCC_INIT        8'h00
`define DTD_LEN_PROCESS     8'h06
`define DTD_LEN_PARAM       8'h0e
`define DTD_LEN_TEXT_MIN    8'h0a
// ***********************
// command / number word fields
// ***********************
`define DTD_CMD_MSB         15
`define DTD_CMD_LSB         12
`define DTD_PNU_MSB         11
`define DTD_PNU_LSB         0
// ***********************
// command codes
// ***********************
`define DTD_CMD_NONE        4'h0
`define DTD_CMD_READ        4'h1
`define DTD_CMD_WR_W        4'h2
`define DTD_CMD_WR_DW       4'h3
`define DTD_CMD_WRE_DW      4'hd
`define DTD_CMD_WRE_W       4'he
`define DTD_CMD_TEXT        4'hf
// ***********************
// response codes
// ***********************
`define DTD_RSP_NONE        4'h0
`define DTD_RSP_WORD        4'h1
`define DTD_RSP_DWORD       4'h2
`define DTD_RSP_FAIL        4'h7
`define DTD_RSP_TEXT        4'hf
// ***********************
// fault numbers
// ***********************
`define DTD_FLT_UNKNOWN     16'h0000
`define DTD_FLT_NO_WRITE    16'h0001
`define DTD_FLT_LIMIT       16'h0002
`define DTD_FLT_SUBIDX      16'h0003
`define DTD_FLT_NOT_ARRAY   16'h0004
`define DTD_FLT_TYPE        16'h0005
`define DTD_FLT_MODE        16'h000b
`define DTD_FLT_NO_BUS      16'h0052
`define DTD_FLT_FACTORY     16'h0053
// ***********************
// index high byte and data types
// ***********************
`define DTD_IDX_TEXT_RD     8'h04
`define DTD_IDX_TEXT_WR     8'h05
`define DTD_TYPE_I16        8'h03
`define DTD_TYPE_I32        8'h04
`define DTD_TYPE_U8         8'h05
`define DTD_TYPE_U16        8'h06
`define DTD_TYPE_U32        8'h07
`define DTD_TYPE_TEXT       8'h09
`define DTD_TYPE_BYTES      8'h0a
`define DTD_TYPE_TDIFF      8'h0d
`define DTD_TYPE_RSVD       8'h21
`define DTD_TYPE_BITS       8'h23
`endif

// file: rtl/dtd_fifo.v
// small valid/ready fifo for response bytes
`timescale 1ns/1ps
module dtd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clock,
  input  wire             nrst,
  // fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // drain side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_reg;
  reg [AW:0]      rd_reg;
  wire            full;
  wire            empty;
  assign empty     = (wr_reg == rd_reg);
  assign full      = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_reg[AW-1:0]];
  always @(posedge clock)
  begin
    if (in_valid && !full)
      mem[wr_reg[AW-1:0]] <= in_data;
  end
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
        wr_reg <= wr_reg + 1'b1;
      if (out_ready && !empty)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule // dtd_fifo

// file: rtl/dtd_data_field.v
// slave-side telegram data-field interpreter
// Operation
// R1 - checksum is running xor, cleared first
// R2 - response uses the request's layout; code sends every reply other than a process reply in the parameter layout
// R3 - process layout is four data bytes
// R4 - process words: control/reference, status/frequency
// R5 - two 16-bit process words, fixed order
// R6 - parameter layout twelve bytes, six words
// R7 - text layout: header, characters, process words; code decodes every non-process telegram in the twelve-byte parameter layout
// R8 - bits 15:12 command, 11:0 number
// R9 - decode the seven command codes
// R10 - return the five response codes
// R11 - failed command: code 7, fault in low
// R12 - only index low byte selects element
// R13 - value block two words, read returns value
// R14 - master writes value with write command
// R15 - text read: command f, index 4
// R16 - text write: command f, index 5
// R17 - text read only for type 9
// R18 - classify parameter data type codes
// R19 - values exchanged as scaled integers
// R20 - enumerated options carried as ordinal
// R21 - telegram starts 02, length, address
// R22 - length is data bytes plus two
// R23 - echo address byte unchanged
// R24 - eleven-bit characters, even parity
// R25 - bad checksum discards, no answer
`timescale 1ns/1ps
`include "dtd_regs.vh"
module dtd_data_field #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW    = 2
) (
  // clock and reset
  input  wire        clock,
  input  wire        nrst,
  // received characters from the uart
  input  wire [7:0]  rx_byte,
  input  wire        rx_valid,
  input  wire        rx_parity_ok,
  // response characters to the uart
  output reg  [7:0]  tx_byte,
  output reg         tx_valid,
  input  wire        tx_ready,
  // parameter store request
  output reg         par_req,
  output reg  [3:0]  par_cmd,
  output reg  [11:0] par_number,
  output reg  [7:0]  par_subindex,
  output reg  [31:0] par_wr_value,
  // parameter store answer
  input  wire        par_done,
  input  wire        par_fail,
  input  wire [15:0] par_fault,
  input  wire [31:0] par_rd_value,
  input  wire [7:0]  par_type,
  // process data
  output reg  [15:0] first_process_word,
  output reg  [15:0] second_process_word,
  output reg         process_strobe,
  input  wire [15:0] status_word,
  input  wire [15:0] output_frequency,
  // status
  output reg         bcc_error
);
  // *************************
  // receive state machine
  // *************************
  localparam S_START = 3'd0;
  localparam S_LEN   = 3'd1;
  localparam S_DATA  = 3'd2;
  localparam S_BCC   = 3'd3;
  localparam S_PAR   = 3'd4;
  localparam S_SEND  = 3'd5;
  reg [2:0]   state_reg;
  reg [7:0]   len_reg;
  reg [7:0]   cnt_reg;
  reg [7:0]   bcc_reg;
  reg [7:0]   addr_reg;
  reg [95:0]  data_reg;
  reg [7:0]   rx_s1_reg;
  reg [7:0]   rx_s2_reg;
  reg [2:0]   v_s_reg;
  reg         ok_s1_reg;
  reg         ok_s2_reg;
  reg [95:0]  rsp_reg;
  reg [7:0]   rsp_len_reg;
  reg [7:0]   rsp_idx_reg;
  reg [7:0]   rsp_bcc_reg;
  wire        rx_new;
  wire [15:0] cnw;
  wire [15:0] subw;
  wire [3:0]  cmd;
  wire        f_ready;
  wire [7:0]  f_data;
  wire        f_valid;
  reg  [7:0]  send_byte;
  // two-stage sampling; valid edge read only past the second stage
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_s1_reg <= 8'h00;
      rx_s2_reg <= 8'h00;
      v_s_reg   <= 3'h0;
      ok_s1_reg <= 1'b0;
      ok_s2_reg <= 1'b0;
    end
    else
    begin
      rx_s1_reg <= rx_byte;
      rx_s2_reg <= rx_s1_reg;
      v_s_reg   <= {v_s_reg[1:0], rx_valid};
      ok_s1_reg <= rx_parity_ok;
      ok_s2_reg <= ok_s1_reg;
    end
  end
  assign rx_new = v_s_reg[1] & ~v_s_reg[2];
  // R8 field split
  assign cnw  = data_reg[95:80];
  assign subw = data_reg[79:64];
  assign cmd  = cnw[`DTD_CMD_MSB:`DTD_CMD_LSB];
  // R9 command decode helper
  function is_write;
    input [3:0] c;
    begin
      is_write = (c == `DTD_CMD_WR_W) || (c == `DTD_CMD_WR_DW) ||
                 (c == `DTD_CMD_WRE_DW) || (c == `DTD_CMD_WRE_W);
    end
  endfunction
  // R18 numeric type check
  function is_numeric;
    input [7:0] t;
    begin
      is_numeric = (t == `DTD_TYPE_I16) || (t == `DTD_TYPE_I32) || (t == `DTD_TYPE_U8) ||
                   (t == `DTD_TYPE_U16) || (t == `DTD_TYPE_U32) || (t == `DTD_TYPE_TDIFF) ||
                   (t == `DTD_TYPE_BITS) || (t == `DTD_TYPE_BYTES);
    end
  endfunction
  // R23 response bytes in order: start, length, address, data, check
  always @*
  begin
    if (rsp_idx_reg == 8'h00)
      send_byte = `DTD_START_CHAR;
    else if (rsp_idx_reg == 8'h01)
      send_byte = rsp_len_reg;
    else if (rsp_idx_reg == 8'h02)
      send_byte = addr_reg;
    else if (rsp_idx_reg == rsp_len_reg + 8'h01)
      send_byte = rsp_bcc_reg;
    else
      send_byte = rsp_reg[95:88];
  end
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg           <= S_START;
      len_reg             <= 8'h00;
      cnt_reg             <= 8'h00;
      bcc_reg             <= `DTD_BCC_INIT;
      addr_reg            <= 8'h00;
      data_reg            <= 96'h0;
      rsp_reg             <= 96'h0;
      rsp_len_reg         <= 8'h00;
      rsp_idx_reg         <= 8'h00;
      rsp_bcc_reg         <= 8'h00;
      par_req             <= 1'b0;
      par_cmd             <= 4'h0;
      par_number          <= 12'h000;
      par_subindex        <= 8'h00;
      par_wr_value        <= 32'h0;
      first_process_word  <= 16'h0000;
      second_process_word <= 16'h0000;
      process_strobe      <= 1'b0;
      bcc_error           <= 1'b0;
    end
    else
    begin
      process_strobe <= 1'b0;
      par_req        <= 1'b0;
      case (state_reg)
        S_START:
        begin
          // R1 checksum cleared before the first byte
          bcc_reg <= `DTD_BCC_INIT;
          // R21 wait for start character; R24 parity failures dropped
          if (rx_new && ok_s2_reg && rx_s2_reg == `DTD_START_CHAR)
          begin
            bcc_reg   <= rx_s2_reg;
            state_reg <= S_LEN;
          end
        end
        S_LEN:
          if (rx_new)
          begin
            // R25 checksum covers all bytes before check byte
            bcc_reg   <= bcc_reg ^ rx_s2_reg;
            len_reg   <= rx_s2_reg;
            cnt_reg   <= 8'h00;
            // R22 length at least address plus check plus four
            if (!ok_s2_reg || rx_s2_reg < `DTD_LEN_PROCESS || rx_s2_reg > `DTD_LEN_PARAM + 8'h0c)
              state_reg <= S_START;
            else
              state_reg <= S_DATA;
          end
        S_DATA:
          if (rx_new)
          begin
            bcc_reg <= bcc_reg ^ rx_s2_reg;
            cnt_reg <= cnt_reg + 8'h01;
            if (cnt_reg == 8'h00)
              addr_reg <= rx_s2_reg;
            else
              data_reg <= {data_reg[87:0], rx_s2_reg};
            if (!ok_s2_reg)
              state_reg <= S_START;
            else if (cnt_reg + 8'h02 == len_reg)
              state_reg <= S_BCC;
          end
        S_BCC:
          if (rx_new)
          begin
            // R25 mismatch discards without reply
            if (rx_s2_reg != bcc_reg || !ok_s2_reg)
            begin
              bcc_error <= 1'b1;
              state_reg <= S_START;
            end
            else
            begin
              bcc_error <= 1'b0;
              // R3 R4 R5 last two words are the process words
              first_process_word  <= data_reg[31:16];
              second_process_word <= data_reg[15:0];
              process_strobe      <= 1'b1;
              if (len_reg == `DTD_LEN_PROCESS)
              begin
                // R2 R4 process reply: status then frequency
                rsp_reg     <= {status_word, output_frequency, 64'h0};
                rsp_len_reg <= `DTD_LEN_PROCESS;
                state_reg   <= S_SEND;
              end
              else
              begin
                // R12 only the low index byte; R13 R14 value block
                par_cmd      <= cmd;
                par_number   <= cnw[`DTD_PNU_MSB:`DTD_PNU_LSB];
                par_subindex <= subw[7:0];
                par_wr_value <= data_reg[63:32];
                par_req      <= (cmd != `DTD_CMD_NONE);
                // R6 R7 parameter reply keeps the long layout
                rsp_len_reg  <= `DTD_LEN_PARAM;
                rsp_reg      <= {`DTD_RSP_NONE, cnw[11:0], subw, 32'h0, status_word, output_frequency};
                if (cmd == `DTD_CMD_NONE)
                  state_reg <= S_SEND;
                else
                  state_reg <= S_PAR;
              end
            end
          end
        S_PAR:
          if (par_done)
          begin
            state_reg <= S_SEND;
            // R11 failure code with fault number in low word
            if (par_fail)
              rsp_reg[95:32] <= {`DTD_RSP_FAIL, par_number, rsp_reg[79:64], 16'h0, par_fault};
            // R15 R16 R17 text needs index 4 or 5 and type 9
            else if (par_cmd == `DTD_CMD_TEXT)
            begin
              if (par_type != `DTD_TYPE_TEXT ||
                  (rsp_reg[79:72] != `DTD_IDX_TEXT_RD && rsp_reg[79:72] != `DTD_IDX_TEXT_WR))
                rsp_reg[95:32] <= {`DTD_RSP_FAIL, par_number, rsp_reg[79:64], 16'h0, `DTD_FLT_TYPE};
              else
                rsp_reg[95:92] <= `DTD_RSP_TEXT;
            end
            // R10 R13 R19 R20 value returned, width by type
            else if (par_cmd == `DTD_CMD_READ || is_write(par_cmd))
            begin
              if (!is_numeric(par_type))
                rsp_reg[95:32] <= {`DTD_RSP_FAIL, par_number, rsp_reg[79:64], 16'h0, `DTD_FLT_TYPE};
              else if (par_type == `DTD_TYPE_I32 || par_type == `DTD_TYPE_U32 ||
                       par_type == `DTD_TYPE_TDIFF)
                rsp_reg[95:32] <= {`DTD_RSP_DWORD, par_number, rsp_reg[79:64], par_rd_value};
              else
                rsp_reg[95:32] <= {`DTD_RSP_WORD, par_number, rsp_reg[79:64], par_rd_value};
            end
            else
              rsp_reg[95:32] <= {`DTD_RSP_FAIL, par_number, rsp_reg[79:64], 16'h0, `DTD_FLT_UNKNOWN};
          end
        S_SEND:
        begin
          if (f_ready)
          begin
            // R1 response checksum built the same way
            if (rsp_idx_reg == 8'h00)
              rsp_bcc_reg <= send_byte;
            else
              rsp_bcc_reg <= rsp_bcc_reg ^ send_byte;
            if (rsp_idx_reg > 8'h02)
              rsp_reg <= {rsp_reg[87:0], 8'h00};
            if (rsp_idx_reg == rsp_len_reg + 8'h01)
            begin
              rsp_idx_reg <= 8'h00;
              state_reg   <= S_START;
            end
            else
              rsp_idx_reg <= rsp_idx_reg + 8'h01;
          end
        end
        default:
          state_reg <= S_START;
      endcase
    end
  end
  // fifo decouples reply generation from a slow uart
  dtd_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_data   (send_byte),
    .in_valid  (state_reg == S_SEND),
    .in_ready  (f_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (~tx_valid | tx_ready)
  );
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_byte  <= 8'h00;
      tx_valid <= 1'b0;
    end
    else if (~tx_valid | tx_ready)
    begin
      tx_byte  <= f_data;
      tx_valid <= f_valid;
    end
  end
endmodule // dtd_data_field

// file: dv/dtd_par_store.sv
// parameter store model answering the request port
`timescale 1ns/1ps
module dtd_par_store (
  // clock and reset
  input  wire        clock,
  input  wire        nrst,
  // request and answer
  input  wire        par_req,
  output wire        par_done,
  output wire        par_fail,
  output wire [15:0] par_fault,
  output wire [31:0] par_rd_value,
  output wire [7:0]  par_type,
  // bench controls
  input  wire [7:0]  dly,
  input  wire        fail,
  input  wire [15:0] fault,
  input  wire [7:0]  typ,
  input  wire [31:0] val
);
  // ****
  // answer timing
  // ****
  reg [7:0] cnt_reg;
  always @(posedge clock or negedge nrst)
    if (!nrst)
      cnt_reg <= 8'h00;
    else if (par_req)
      cnt_reg <= dly + 8'h01;
    else if (cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;
  assign par_done = (cnt_reg == 8'h01);
  // value, type or fault
  // outside the answer cycle the lines carry junk, not the last value
  assign par_fail     = par_done ? fail : ~fail;
  assign par_fault    = par_done ? fault : ~fault;
  assign par_rd_value = par_done ? val : ~val;
  assign par_type     = par_done ? typ : ~typ;
endmodule // dtd_par_store

// file: dv/dtd_data_field_properties.sv
// port assertions for the data-field block
`timescale 1ns/1ps
module dtd_df_props (
  // clock and reset
  input wire        clock,
  input wire        nrst,
  // serial side
  input wire [7:0]  rx_byte,
  input wire        rx_valid,
  input wire        rx_parity_ok,
  input wire [7:0]  tx_byte,
  input wire        tx_valid,
  input wire        tx_ready,
  // store side
  input wire        par_req,
  input wire [3:0]  par_cmd,
  input wire [11:0] par_number,
  input wire [7:0]  par_subindex,
  input wire [31:0] par_wr_value,
  input wire        par_done,
  input wire        par_fail,
  input wire [15:0] par_fault,
  input wire [31:0] par_rd_value,
  input wire [7:0]  par_type,
  // process and status
  input wire [15:0] first_process_word,
  input wire [15:0] second_process_word,
  input wire        process_strobe,
  input wire [15:0] status_word,
  input wire [15:0] output_frequency,
  input wire        bcc_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ****
  // properties
  // ****
  reg pend_reg;
  always @(posedge clock or negedge nrst)
    if (!nrst)
      pend_reg <= 1'b0;
    else if (par_done)
      pend_reg <= 1'b0;
    else if (par_req)
      pend_reg <= 1'b1;
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("reply byte dropped before accept");
  req_pulse_a: assert property (par_req |=> !par_req)
    else $error("store request wider than a cycle");
  req_fields_a: assert property (par_req |=> ($stable(par_cmd) && $stable(par_number)) [*4])
    else $error("request fields moved");
  strobe_pulse_a: assert property (process_strobe |=> !process_strobe)
    else $error("process strobe too wide");
  pw_change_a: assert property (!$stable(first_process_word) || !$stable(second_process_word)
    |-> process_strobe || $past(process_strobe))
    else $error("process word moved without strobe");
  bcc_quiet_a: assert property ($rose(bcc_error) |-> !tx_valid [*8])
    else $error("reply after bad check byte");
  reply_due_a: assert property (par_done |-> ##[1:16] tx_valid)
    else $error("no reply after store answer");
  wait_quiet_a: assert property (pend_reg |-> !tx_valid)
    else $error("reply before store answer");
  cover property (process_strobe);
  cover property (par_done && par_fail);
  cover property ($rose(bcc_error));
endmodule // dtd_df_props

// file: dv/tb_dtd_data_field.sv
// self-checking bench for the data-field block
`timescale 1ns/1ps
module tb_dtd_data_field;
  reg         clock = 1'b0;
  reg         nrst = 1'b0;
  reg  [7:0]  rx_byte = 8'h00;
  reg         rx_valid = 1'b0;
  reg         rx_parity_ok = 1'b1;
  reg         tx_ready = 1'b0;
  reg         hold = 1'b0;
  reg  [15:0] status_word = 16'h0000;
  reg  [15:0] output_frequency = 16'h0000;
  reg  [7:0]  dly = 8'h00;
  reg         fail = 1'b0;
  reg  [15:0] fault = 16'h0000;
  reg  [7:0]  typ = 8'h00;
  wire [31:0] val = 32'h89ab_cdef;
  wire [7:0]  tx_byte, par_subindex, par_type;
  wire        tx_valid, par_req, par_done, par_fail, process_strobe, bcc_error;
  wire [3:0]  par_cmd;
  wire [11:0] par_number;
  wire [31:0] par_wr_value, par_rd_value;
  wire [15:0] par_fault, first_process_word, second_process_word;
  int         error_cnt = 0;
  int         n_checks = 0;
  int         nstb = 0;
  int         nreq = 0;
  int         i;
  logic [7:0] rq[$], tq[$], eq[$];
  logic [7:0] a, ih, ty;
  logic [15:0] p1, p2, sw, fq, ft, dcm;
  logic [3:0] c, rc, fl, md;
  logic [31:0] ev;
  localparam logic [71:0] PROC [0:2] = '{72'h01_1122_3344_5566_7788,
    72'h81_ffff_0000_a5a5_0001, 72'h1f_0000_ffff_0000_ffff};
  // cmd, index high, type, fault, response, fail, value mode
  localparam logic [47:0] PRM [0:13] = '{48'h1_00_06_0000_1_0_1, 48'h1_00_07_0000_2_0_0,
    48'h1_00_0d_0000_2_0_0, 48'h2_00_03_0000_1_0_1, 48'h3_00_04_0000_2_0_0, 48'h d_00_07_0000_2_0_0,
    48'he_00_05_0000_1_0_1, 48'h1_00_06_0053_7_1_1, 48'h2_00_06_000b_7_1_1, 48'hf_04_09_0000_f_0_2,
    48'hf_05_09_0000_f_0_2, 48'hf_04_06_0005_7_0_1, 48'hf_06_09_0005_7_0_1, 48'h4_00_06_0000_7_0_1};
  dtd_data_field dut (.*);
  dtd_par_store u_store (.*);
  always #25 clock = ~clock;
  // ****
  // tasks
  // ****
  // half-rate accept plus one long stall (second process telegram) so the reply fifo fills
  always @(posedge clock)
  begin
    tx_ready <= ~tx_ready & ~hold;
    if (tx_valid && tx_ready)
      rq.push_back(tx_byte);
    if (process_strobe)
      nstb++;
    if (par_req)
      nreq++;
  end
  task finish_test;
  begin
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk(input [31:0] g, input [31:0] e);
  begin
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  end
  endtask
  task put(input [7:0] b, input p);
  begin
    rx_byte <= b;
    rx_parity_ok <= p;
    rx_valid <= 1'b1;
    repeat (3) @(posedge clock);
    rx_valid <= 1'b0;
    repeat (3) @(posedge clock);
  end
  endtask
  task send(input bit bad, input int bp);
    int k;
    logic [7:0] x;
  begin
    x = 8'h00;
    for (k = 0; k < tq.size(); k++)
    begin
      x = x ^ tq[k];
      put(tq[k], k != bp);
    end
    put(x ^ {8{bad}}, 1'b1);
  end
  endtask
  task wait_rx(input int n);
    int k;
  begin
    for (k = 0; k < 3000 && rq.size() < n; k++)
      @(posedge clock);
    if (rq.size() < n)
    begin
      error_cnt++;
      $display("[FAIL] %0t reply missing", $time);
      finish_test;
    end
    repeat (4) @(posedge clock);
  end
  endtask
  task chk_rep;
    int k;
    logic [7:0] x;
  begin
    x = 8'h00;
    chk(rq.size(), eq.size() + 1);
    for (k = 0; k < eq.size(); k++)
    begin
      if (!dcm[k])
        chk(rq[k], eq[k]);
      x = x ^ rq[k];
    end
    chk(rq[eq.size()], x);
    rq.delete();
  end
  endtask
  // ****
  // sequence
  // ****
  initial
  begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    chk({tx_valid, par_req, process_strobe, bcc_error}, 4'h0);
    put(8'h55, 1'b1);
    dcm = 16'h0000;
    for (i = 0; i < 3; i++)
    begin
      {a, p1, p2, sw, fq} = PROC[i];
      status_word <= sw;
      output_frequency <= fq;
      hold <= (i == 1);
      tq = '{8'h02, 8'h06, a, p1[15:8], p1[7:0], p2[15:8], p2[7:0]};
      send(1'b0, -1);
      repeat (20) @(posedge clock);
      hold <= 1'b0;
      wait_rx(8);
      chk(first_process_word, p1);
      chk(second_process_word, p2);
      chk(nstb, i + 1);
      eq = '{8'h02, 8'h06, a, sw[15:8], sw[7:0], fq[15:8], fq[7:0]};
      chk_rep;
    end
    for (i = 0; i < 14; i++)
    begin
      {c, ih, ty, ft, rc, fl, md} = PRM[i];
      typ <= ty;
      fail <= fl[0];
      fault <= ft;
      dly <= 8'(i * 5);
      tq = '{8'h02, 8'h0e, 8'h01, {c, 4'h1}, 8'h9e, ih, 8'h07, 8'h12, 8'h34, 8'h56, 8'h78,
        8'h00, 8'h01, 8'h00, 8'h02};
      send(1'b0, -1);
      wait_rx(16);
      chk(par_cmd, c);
      chk(par_number, 12'h19e);
      chk(par_subindex, 8'h07);
      chk(par_wr_value, 32'h1234_5678);
      chk(nreq, i + 1);
      chk(second_process_word, 16'h0002);
      ev = (rc == 4'h7) ? {16'h0000, ft} : val;
      dcm = (md == 4'h0) ? 16'h0060 : (md == 4'h1) ? 16'h01e0 : 16'h07e0;
      eq = '{8'h02, 8'h0e, 8'h01, {rc, 4'h1}, 8'h9e, 8'h00, 8'h00, ev[31:24], ev[23:16], ev[15:8],
        ev[7:0], status_word[15:8], status_word[7:0], output_frequency[15:8], output_frequency[7:0]};
      chk_rep;
    end
    tq = '{8'h02, 8'h06, 8'h01, 8'hde, 8'had, 8'hbe, 8'hef};
    send(1'b1, -1);
    repeat (60) @(posedge clock);
    chk(bcc_error, 1'b1);
    send(1'b0, 3);
    repeat (60) @(posedge clock);
    chk(rq.size(), 0);
    chk(first_process_word, 16'h0001);
    send(1'b0, -1);
    wait_rx(8);
    chk(bcc_error, 1'b0);
    chk(first_process_word, 16'hdead);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    chk(first_process_word, 16'h0000);
    finish_test;
  end
endmodule // tb_dtd_data_field
bind dtd_data_field dtd_df_props u_props (.*);
